// >>> design/tcb_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TCB_MAP_SVH
`define TCB_MAP_SVH
`define TCB_OFF_CTRL      12'h000
`define TCB_OFF_PER_LO    12'h004
`define TCB_OFF_PER_HI    12'h008
`define TCB_OFF_TOG_LO    12'h00C
`define TCB_OFF_TOG_HI    12'h010
`define TCB_OFF_COUNT     12'h014
`define TCB_OFF_STATUS    12'h018
`define TCB_OFF_MASK      12'h01C
`define TCB_OFF_FILT      12'h020
`define TCB_CTRL_RUN      0
`define TCB_CTRL_SHADOW   1
`define TCB_CTRL_FSEL_LO  2
`define TCB_CTRL_LOWFREQ  4
`define TCB_ST_PMATCH     0
`define TCB_ST_TMATCH     1
`define TCB_ST_OVF        2
`define TCB_ST_EDGE       3
`define TCB_NUM_EV        4
`define TCB_CMP_RST       16'hFFFF
`define TCB_DIV_F01       9'd2
`define TCB_DIV_F10       9'd4
`define TCB_DIV_F11       9'd256
`define TCB_LF_DIV        2'd2
`define TCB_SAMPLES       2'd3
`endif

// >>> design/tcb_pkg.sv
// Types shared by the timer compare buffer and input filter
package tcb_pkg;
   typedef struct packed {
      logic [15:0] act;
      logic [15:0] shd;
   } tcb_cmp_s;
   typedef struct packed {
      logic        run;
      logic        shadow_enable;
      logic [1:0]  input_filter_select;
      logic        low_freq_mode;
   } tcb_ctrl_s;
   typedef struct packed {
      logic [7:0]  hold;
      tcb_cmp_s    per;
      tcb_cmp_s    tog;
      tcb_ctrl_s   ctrl;
      logic [15:0] count;
      logic [8:0]  div;
      logic [1:0]  lf_div;
      logic [1:0]  agree;
      logic        last_smp;
      logic        filt;
      logic [3:0]  status;
      logic [3:0]  mask;
      logic [31:0] prdata;
      logic        pslverr;
   } tcb_state_s;
endpackage : tcb_pkg

// >>> design/tcb_top.sv
// Compare write buffering, 16-bit counter and timer input noise filter
//
// Notes on behaviour
// RQ1 - Low-byte write goes to shared holding byte
// RQ2 - High-byte write commits high and held low
// RQ3 - Software writes low byte then high byte
// RQ4 - Shadow enable bit: 0 off, 1 on
// RQ5 - Shadow on, running: write fills shadow only
// RQ6 - Shadow on: match raises irq, loads shadow
// RQ7 - Shadow on: reads return shadow contents
// RQ8 - Shadow on, stopped: load shadow and active
// RQ9 - Shadow off: write takes effect at once
// RQ10 - Shadow off: value below count waits overflow
// RQ11 - Filter serves every mode using input pin
// RQ12 - Level changes after three equal samples
// RQ13 - Nonzero filter select runs regardless of run
// RQ14 - Software waits four intervals before starting
// RQ15 - Filter select writes ignored while running
// RQ16 - Low-freq: 11 every second tick, 01/10 block
// RQ17 - Intervals 2, 4 and 256 gear clocks
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "tcb_map.svh"
module tcb_top (
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Low-frequency clock tick, one pclk cycle wide
   input  wire logic        low_freq_clock,
   // Timer input pin
   input  wire logic        timer_input_pin,
   // Timer outputs
   output logic             filtered_input,
   output logic             timer_irq
);
   tcb_pkg::tcb_state_s s_r;
   tcb_pkg::tcb_state_s s_nxt;
   logic pin_meta_r;
   logic pin_sync_r;
   logic lf_meta_r;
   logic lf_sync_r;
   logic lf_prev_r;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_r <= 1'b0;
         pin_sync_r <= 1'b0;
         lf_meta_r  <= 1'b0;
         lf_sync_r  <= 1'b0;
         lf_prev_r  <= 1'b0;
      end else begin
         pin_meta_r <= timer_input_pin;
         pin_sync_r <= pin_meta_r;
         lf_meta_r  <= low_freq_clock;
         lf_sync_r  <= lf_meta_r;
         lf_prev_r  <= lf_sync_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   logic        wr;
   logic        rd;
   logic        setup;
   logic        smp_tick;
   logic        pin_block;
   logic        pin_val;
   logic        pmatch;
   logic        tmatch;
   logic        ovf;
   logic        edge_ev;
   logic [3:0]  ev;
   logic [15:0] wv;
   logic        lf_rise;
   logic [8:0]  div_lim;

   assign pready = 1'b1;
   assign wr = psel & penable & pwrite;
   assign setup = psel & ~penable;
   assign rd = setup & ~pwrite;
   assign lf_rise = lf_sync_r & ~lf_prev_r;

   always_comb begin
      s_nxt = s_r;
      ev = 4'h0;
      wv = {pwdata[7:0], s_r.hold};
      smp_tick = 1'b0;
      div_lim = `TCB_DIV_F11;
      pin_block = 1'b0;
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = 32'h0000_0000;

      // Counter with compare against the active values
      pmatch = s_r.ctrl.run && (s_r.count == s_r.per.act);
      tmatch = s_r.ctrl.run && (s_r.count == s_r.tog.act);
      ovf = s_r.ctrl.run && (s_r.count == 16'hFFFF) && !pmatch;
      if (s_r.ctrl.run) begin
         if (pmatch) begin
            s_nxt.count = 16'h0000;
         end else begin
            // Value below count: wraps via overflow first
            s_nxt.count = s_r.count + 16'h0001; // RQ10
         end
      end else begin
         s_nxt.count = 16'h0000;
      end
      if (pmatch && s_r.ctrl.shadow_enable) begin
         s_nxt.per.act = s_r.per.shd; // RQ6
         s_nxt.tog.act = s_r.tog.shd; // RQ6
      end

      // Noise filter sample clock
      if (s_r.ctrl.low_freq_mode) begin
         pin_block = (s_r.ctrl.input_filter_select == 2'b01) ||
                     (s_r.ctrl.input_filter_select == 2'b10); // RQ16
         if (lf_rise) begin
            s_nxt.lf_div = s_r.lf_div + 2'd1;
            if (s_r.lf_div == `TCB_LF_DIV - 2'd1) begin
               s_nxt.lf_div = 2'd0;
               smp_tick = 1'b1; // RQ16
            end
         end
      end else begin
         case (s_r.ctrl.input_filter_select)
            2'b01:   div_lim = `TCB_DIV_F01; // RQ17
            2'b10:   div_lim = `TCB_DIV_F10; // RQ17
            default: div_lim = `TCB_DIV_F11; // RQ17
         endcase
         s_nxt.div = s_r.div + 9'd1;
         if (s_r.div >= div_lim - 9'd1) begin
            s_nxt.div = 9'd0;
            smp_tick = 1'b1;
         end
      end

      // Filter runs whenever select is nonzero and the pin is not blocked, run bit aside
      pin_val = pin_block ? 1'b0 : pin_sync_r;
      if (s_r.ctrl.input_filter_select == 2'b00) begin // RQ13
         s_nxt.filt = pin_val; // RQ16
         s_nxt.agree = 2'd0;
      end else if (smp_tick && !pin_block) begin
         s_nxt.last_smp = pin_sync_r;
         if (pin_sync_r == s_r.filt) begin
            s_nxt.agree = 2'd0;
         end else if (pin_sync_r != s_r.last_smp) begin
            s_nxt.agree = 2'd1;
         end else if (s_r.agree == `TCB_SAMPLES - 2'd1) begin
            s_nxt.filt = pin_sync_r; // RQ12
            s_nxt.agree = 2'd0;
         end else begin
            s_nxt.agree = s_r.agree + 2'd1;
         end
      end
      edge_ev = s_nxt.filt != s_r.filt; // RQ11

      // APB writes
      if (wr) begin
         case (paddr)
            `TCB_OFF_CTRL: begin
               s_nxt.ctrl.run = pwdata[`TCB_CTRL_RUN];
               s_nxt.ctrl.shadow_enable = pwdata[`TCB_CTRL_SHADOW]; // RQ4
               s_nxt.ctrl.low_freq_mode = pwdata[`TCB_CTRL_LOWFREQ];
               if (!s_r.ctrl.run) begin
                  s_nxt.ctrl.input_filter_select =
                     pwdata[`TCB_CTRL_FSEL_LO +: 2]; // RQ15
               end
            end
            `TCB_OFF_PER_LO, `TCB_OFF_TOG_LO: begin
               s_nxt.hold = pwdata[7:0]; // RQ1
            end
            `TCB_OFF_PER_HI: begin
               s_nxt.per.shd = wv; // RQ2
               if (!(s_r.ctrl.shadow_enable && s_r.ctrl.run)) begin
                  s_nxt.per.act = wv; // RQ5 RQ8 RQ9
               end
            end
            `TCB_OFF_TOG_HI: begin
               s_nxt.tog.shd = wv; // RQ2
               if (!(s_r.ctrl.shadow_enable && s_r.ctrl.run)) begin
                  s_nxt.tog.act = wv; // RQ5 RQ8 RQ9
               end
            end
            `TCB_OFF_STATUS: s_nxt.status = s_r.status & ~pwdata[3:0];
            `TCB_OFF_MASK:   s_nxt.mask = pwdata[3:0];
            `TCB_OFF_COUNT, `TCB_OFF_FILT: ;
            default: ;
         endcase
      end

      // Decode in setup so that the error stands in the access phase
      if (setup) begin
         case (paddr)
            `TCB_OFF_CTRL, `TCB_OFF_PER_LO, `TCB_OFF_PER_HI,
            `TCB_OFF_TOG_LO, `TCB_OFF_TOG_HI, `TCB_OFF_COUNT,
            `TCB_OFF_STATUS, `TCB_OFF_MASK, `TCB_OFF_FILT: ;
            default: s_nxt.pslverr = 1'b1;
         endcase
      end

      // Event capture: set wins over write-one-to-clear
      ev[`TCB_ST_PMATCH] = pmatch; // RQ6
      ev[`TCB_ST_TMATCH] = tmatch;
      ev[`TCB_ST_OVF] = ovf;
      ev[`TCB_ST_EDGE] = edge_ev;
      s_nxt.status = s_nxt.status | ev;

      // APB reads, loaded in setup so data stands in the access phase
      if (rd) begin
         case (paddr)
            `TCB_OFF_CTRL: s_nxt.prdata = {27'h0, s_r.ctrl.low_freq_mode,
               s_r.ctrl.input_filter_select, s_r.ctrl.shadow_enable,
               s_r.ctrl.run};
            `TCB_OFF_PER_LO: s_nxt.prdata = {24'h0, s_r.per.shd[7:0]};
            `TCB_OFF_PER_HI: s_nxt.prdata = {24'h0, s_r.per.shd[15:8]};
            `TCB_OFF_TOG_LO: s_nxt.prdata = {24'h0, s_r.tog.shd[7:0]};
            `TCB_OFF_TOG_HI: s_nxt.prdata = {24'h0, s_r.tog.shd[15:8]}; // RQ7
            `TCB_OFF_COUNT:  s_nxt.prdata = {16'h0, s_r.count};
            `TCB_OFF_STATUS: s_nxt.prdata = {28'h0, s_r.status};
            `TCB_OFF_MASK:   s_nxt.prdata = {28'h0, s_r.mask};
            `TCB_OFF_FILT:   s_nxt.prdata = {31'h0, s_r.filt};
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '{hold: 8'h00,
                  per: '{act: `TCB_CMP_RST, shd: `TCB_CMP_RST},
                  tog: '{act: `TCB_CMP_RST, shd: `TCB_CMP_RST},
                  ctrl: '{run: 1'b0, shadow_enable: 1'b0,
                          input_filter_select: 2'b00,
                          low_freq_mode: 1'b0},
                  count: 16'h0000, div: 9'd0, lf_div: 2'd0,
                  agree: 2'd0, last_smp: 1'b0, filt: 1'b0,
                  status: 4'h0, mask: 4'h0, prdata: 32'h0000_0000,
                  pslverr: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Read data and error come from flops loaded in setup
   always_comb begin
      prdata = s_r.prdata;
      pslverr = s_r.pslverr;
   end
   assign filtered_input = s_r.filt;
   assign timer_irq = |(s_r.status & s_r.mask);
endmodule : tcb_top

// >>> testbench/tcb_props.sv
// Port-level checker for the compare buffer and input filter block
`timescale 1ns/1ps
module tcb_props (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pins
   input wire logic        low_freq_clock,
   input wire logic        timer_input_pin,
   input wire logic        filtered_input,
   input wire logic        timer_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_bad;
      psel && penable && paddr > 12'h020;
   endsequence
   AST_ERR_SET: assert property (s_bad |-> pslverr)
      else $error("unmapped access without error");
   AST_ERR_OK: assert property (psel && penable && paddr[1:0] == 2'b00 &&
      paddr <= 12'h020 |-> !pslverr)
      else $error("error on mapped access");
   AST_ERR_ONLY: assert property (pslverr |-> psel && penable)
      else $error("error without access");
   AST_RD_ONLY: assert property (prdata != 32'h0 |->
      psel && penable && !pwrite)
      else $error("read data without read");
   AST_BAD_RD: assert property (s_bad |-> prdata == 32'h0)
      else $error("read data from unmapped place");
   AST_IRQ_FALL: assert property ($fell(timer_irq) |->
      $past(psel && penable && pwrite))
      else $error("interrupt dropped without write");
   AST_FILT_RISE: assert property ($rose(filtered_input) |->
      $past(timer_input_pin, 2) || $past(timer_input_pin, 3)
      || $past(timer_input_pin, 4))
      else $error("filtered level rose without pin high");
   AST_FILT_FALL: assert property ($fell(filtered_input) |->
      !$past(timer_input_pin, 2) || !$past(timer_input_pin, 3)
      || !$past(timer_input_pin, 4))
      else $error("filtered level fell without pin low");
endmodule : tcb_props
////////////////////////////////////////////////////////////////////////
bind tcb_top tcb_props tcb_props_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .low_freq_clock(low_freq_clock), .timer_input_pin(timer_input_pin),
   .filtered_input(filtered_input), .timer_irq(timer_irq));

// >>> testbench/tcb_pulse_src.sv
// Pulse source model driving the timer input pin
`timescale 1ns/1ps
module tcb_pulse_src (
   // Clock
   input wire logic pclk,
   // Pin
   output logic     timer_input_pin
);
   initial timer_input_pin = 1'b0;
   // Pin high for w cycles, changed just after rising edges
   task automatic pulse(input int w);
      @(posedge pclk);
      timer_input_pin <= 1'b1;
      repeat (w) @(posedge pclk);
      timer_input_pin <= 1'b0;
   endtask : pulse
endmodule : tcb_pulse_src

// >>> testbench/tb_top.sv
// Testbench for compare buffering, interrupt and input filter
`timescale 1ns/1ps
`include "tcb_map.svh"
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, lf, pin, pready;
   logic        pslverr, filt, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   int          mismatches = 0, checked = 0, cyc = 0, dv;
   tcb_top tcb_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .low_freq_clock(lf), .timer_input_pin(pin),
      .filtered_input(filt), .timer_irq(irq));
   tcb_pulse_src tcb_pulse_src_i (.pclk(pclk), .timer_input_pin(pin));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   // Low-frequency tick every 8 cycles, and hang limit
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      lf  <= (cyc % 8 == 0);
      if (cyc == 90000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Answer taken at the edge that samples pready high
      do begin
         @(posedge pclk);
         rv  = prdata;
         err = pslverr;
      end while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : wt
   task automatic wirq(input int n);
      for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge pclk);
      #1;
   endtask : wirq
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      wt(3);
      presetn <= 1'b1;
      xfer(0, `TCB_OFF_PER_HI, 32'h0);
      chk("per_hi_rst", rv[7:0], 8'hFF);
      xfer(1, `TCB_OFF_PER_LO, 32'h5);
      xfer(0, `TCB_OFF_PER_LO, 32'h0);
      chk("per_lo_held", rv[7:0], 8'hFF);
      xfer(1, `TCB_OFF_PER_HI, 32'h0);
      xfer(0, `TCB_OFF_PER_LO, 32'h0);
      chk("per_lo", rv[7:0], 8'h05);
      xfer(1, `TCB_OFF_TOG_LO, 32'h34);
      xfer(1, `TCB_OFF_TOG_HI, 32'h56);
      xfer(0, `TCB_OFF_TOG_HI, 32'h0);
      chk("tog_hi", rv[7:0], 8'h56);
      xfer(0, `TCB_OFF_TOG_LO, 32'h0);
      chk("tog_lo", rv[7:0], 8'h34);
      xfer(0, 12'h024, 32'h0);
      chk("slverr", err, 1'b1);
      xfer(1, `TCB_OFF_MASK, 32'h1);
      xfer(1, `TCB_OFF_CTRL, 32'h1);
      wirq(50);
      chk("irq", irq, 1'b1);
      xfer(1, `TCB_OFF_MASK, 32'h0);
      wt(1);
      chk("irq_masked", irq, 1'b0);
      xfer(1, `TCB_OFF_MASK, 32'h1);
      xfer(1, `TCB_OFF_CTRL, 32'hD);
      xfer(0, `TCB_OFF_CTRL, 32'h0);
      chk("fsel_locked", rv[3:2], 2'b00);
      xfer(1, `TCB_OFF_CTRL, 32'h3);
      xfer(1, `TCB_OFF_PER_LO, 32'h0);
      xfer(1, `TCB_OFF_PER_HI, 32'h1);
      xfer(0, `TCB_OFF_PER_HI, 32'h0);
      chk("per_shadow", rv[7:0], 8'h01);
      wt(40);
      xfer(0, `TCB_OFF_COUNT, 32'h0);
      chk("count_new", rv[15:0] > 16'd5, 1'b1);
      xfer(1, `TCB_OFF_CTRL, 32'h1);
      xfer(1, `TCB_OFF_STATUS, 32'hF);
      xfer(1, `TCB_OFF_PER_LO, 32'h5);
      xfer(1, `TCB_OFF_PER_HI, 32'h0);
      wirq(70000);
      chk("irq_after", irq, 1'b1);
      xfer(0, `TCB_OFF_STATUS, 32'h0);
      chk("wrapped", rv[2], 1'b1);
      chk("tog_match", rv[1], 1'b1);
      // Stop the timer so the filter select is taken
      xfer(1, `TCB_OFF_CTRL, 32'h0);
      for (int s = 1; s < 4; s++) begin
         dv = (s == 3) ? 256 : 2 * s;
         xfer(1, `TCB_OFF_CTRL, s << 2);
         wt(4 * dv);
         tcb_pulse_src_i.pulse(2 * dv - 1);
         wt(3 * dv);
         chk("filt_short", filt, 1'b0);
         tcb_pulse_src_i.pulse(4 * dv + 4);
         #1;
         chk("filt_long", filt, 1'b1);
         wt(4 * dv + 8);
      end
      xfer(1, `TCB_OFF_CTRL, 32'h0);
      tcb_pulse_src_i.pulse(6);
      #1;
      chk("filt_off", filt, 1'b1);
      wt(8);
      xfer(1, `TCB_OFF_CTRL, 32'h14);
      tcb_pulse_src_i.pulse(200);
      #1;
      chk("filt_blocked", filt, 1'b0);
      xfer(1, `TCB_OFF_CTRL, 32'h1C);
      wt(64);
      tcb_pulse_src_i.pulse(84);
      #1;
      chk("filt_slow", filt, 1'b1);
      conclude();
   end
endmodule : tb_top
